// ---- logic/crs_pkg.sv ----
// Constants of the programmer-visible register set: bus offsets, flag layout,
// reset values and access sizes.
// Assumes a single 100 MHz core clock and a 32-bit Avalon-MM register bus.
package crs_pkg;

  // Byte offsets on the register bus, one aligned word each
  localparam logic [7:0] OFF_R0      = 8'h00;
  localparam logic [7:0] OFF_R1      = 8'h04;
  localparam logic [7:0] OFF_R2      = 8'h08;
  localparam logic [7:0] OFF_R3      = 8'h0c;
  localparam logic [7:0] OFF_A0      = 8'h10;
  localparam logic [7:0] OFF_A1      = 8'h14;
  localparam logic [7:0] OFF_FB      = 8'h18;
  localparam logic [7:0] OFF_SB      = 8'h1c;
  localparam logic [7:0] OFF_VECTOR_TABLE_BASE    = 8'h20;
  localparam logic [7:0] OFF_PC      = 8'h24;
  localparam logic [7:0] OFF_USP     = 8'h28;
  localparam logic [7:0] OFF_ISP     = 8'h2c;
  localparam logic [7:0] OFF_SP      = 8'h30;
  localparam logic [7:0] OFF_FLG     = 8'h34;
  localparam logic [7:0] OFF_PAIR_D0 = 8'h38;
  localparam logic [7:0] OFF_PAIR_D1 = 8'h3c;
  localparam logic [7:0] OFF_PAIR_A  = 8'h40;

  // Register index, shared by the bus and the core write port
  localparam int          IDX_W      = 5;
  localparam logic [4:0]  IDX_R0     = OFF_R0[6:2];
  localparam logic [4:0]  IDX_R1     = OFF_R1[6:2];
  localparam logic [4:0]  IDX_R2     = OFF_R2[6:2];
  localparam logic [4:0]  IDX_R3     = OFF_R3[6:2];
  localparam logic [4:0]  IDX_A0     = OFF_A0[6:2];
  localparam logic [4:0]  IDX_A1     = OFF_A1[6:2];
  localparam logic [4:0]  IDX_FB     = OFF_FB[6:2];
  localparam logic [4:0]  IDX_SB     = OFF_SB[6:2];
  localparam logic [4:0]  IDX_VECTOR_TABLE_BASE   = OFF_VECTOR_TABLE_BASE[6:2];
  localparam logic [4:0]  IDX_PC     = OFF_PC[6:2];
  localparam logic [4:0]  IDX_USP    = OFF_USP[6:2];
  localparam logic [4:0]  IDX_ISP    = OFF_ISP[6:2];
  localparam logic [4:0]  IDX_SP     = OFF_SP[6:2];
  localparam logic [4:0]  IDX_FLG    = OFF_FLG[6:2];
  localparam logic [4:0]  IDX_PAIR_D0 = OFF_PAIR_D0[6:2];
  localparam logic [4:0]  IDX_PAIR_D1 = OFF_PAIR_D1[6:2];
  localparam logic [4:0]  IDX_PAIR_A = OFF_PAIR_A[6:2];
  localparam logic [4:0]  IDX_NONE   = 5'h1f;

  // Storage: banked registers per bank, then the shared ones
  localparam int          NUM_BANKED = 7;
  localparam int          NUM_REGS   = 2 * NUM_BANKED + 5;
  localparam int          WORD_W     = 16;
  localparam int          WIDE_W     = 20;
  localparam logic [19:0] REG_RESET  = 20'h00000;

  // Status flag layout
  localparam int          FLG_W      = 11;
  localparam int          FLG_C      = 0;
  localparam int          FLG_D      = 1;
  localparam int          FLG_Z      = 2;
  localparam int          FLG_S      = 3;
  localparam int          FLG_B      = 4;
  localparam int          FLG_O      = 5;
  localparam int          FLG_I      = 6;
  localparam int          FLG_U      = 7;
  localparam int          FLG_IPL    = 8;
  localparam int          FLG_RSV    = 11;
  localparam logic [10:0] FLG_RESET  = 11'h000;

  // Software interrupt numbers up to this one switch to the interrupt stack
  localparam logic [5:0]  SW_INT_U_MAX = 6'h1f;

  typedef enum logic [1:0] {
    CRS_SZ_BYTE_LO,
    CRS_SZ_BYTE_HI,
    CRS_SZ_WORD,
    CRS_SZ_LONG
  } crs_size_t;

endpackage

// ---- logic/crs_register_set.sv ----
// Register set of a 16-bit core with its status flags, reached by the core
// through a write port and by software through an Avalon-MM slave.
// Assumes execution, arithmetic and interrupt logic sit outside and drive
// the core-side ports synchronously to clock.
`timescale 1ns/1ps

module crs_register_set (
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 nrst,
  // Avalon-MM slave
  input  wire logic [7:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  input  wire logic [3:0]           avs_byteenable,
  output      logic [31:0]          avs_readdata,
  output      logic                 avs_waitrequest,
  // Core write port
  input  wire logic                 core_wr,
  input  wire logic [4:0]           core_wr_idx,
  input  wire crs_pkg::crs_size_t   core_wr_size,
  input  wire logic [31:0]          core_wr_data,
  // Arithmetic unit flag update
  input  wire logic                 alu_update,
  input  wire logic                 alu_byte,
  input  wire logic [15:0]          alu_result,
  input  wire logic                 alu_carry,
  input  wire logic                 alu_overflow,
  input  wire logic [3:0]           alu_flag_mask,
  // Interrupt request and acceptance
  input  wire logic                 irq_req,
  input  wire logic                 irq_maskable,
  input  wire logic [2:0]           irq_level,
  input  wire logic                 ack_hw,
  input  wire logic                 ack_sw,
  input  wire logic [5:0]           ack_sw_num,
  output      logic                 irq_permit,
  // Register views for the core
  output      logic [31:0]          data_pair_low,
  output      logic [31:0]          data_pair_high,
  output      logic [31:0]          addr_pair,
  output      logic [15:0]          frame_base,
  output      logic [15:0]          static_base,
  output      logic [19:0]          vector_table_base,
  output      logic [19:0]          next_instr_address,
  output      logic [15:0]          active_sp,
  output      logic [10:0]          cpu_status_flags,
  output      logic                 bank_sel,
  output      logic                 int_enable,
  output      logic [2:0]           processor_priority_level
);

  localparam int NR = crs_pkg::NUM_REGS;

  // Reset release through two flops
  logic [1:0]  rst_sync_reg;
  wire  logic  rst_n = rst_sync_reg[1];

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  // Storage
  logic [19:0] file_reg  [NR];
  logic [19:0] file_next [NR];
  logic [10:0] flag_reg;
  logic [10:0] flag_next;
  logic        wait_reg;
  logic [31:0] rdata_reg;
  logic        permit_reg;
  logic [31:0] pair_lo_reg;
  logic [31:0] pair_hi_reg;
  logic [31:0] apair_reg;
  logic [15:0] fb_reg;
  logic [15:0] sb_reg;
  logic [19:0] vector_table_base_reg;
  logic [19:0] pc_reg;
  logic [15:0] sp_reg;
  logic [10:0] flg_out_reg;

  // Banked registers follow the bank flag; the rest are shared
  function automatic logic [4:0] phys(input logic [4:0] idx, input logic bank);
    if (idx < 5'(crs_pkg::NUM_BANKED)) begin
      phys = bank ? 5'(idx + 5'(crs_pkg::NUM_BANKED)) : idx;
    end else begin
      phys = 5'(idx + 5'(crs_pkg::NUM_BANKED));
    end
  endfunction

  // The stack pointer alias lands on one of the two pointers
  function automatic logic [4:0] resolve_sp(input logic [4:0] idx, input logic u);
    if (idx == crs_pkg::IDX_SP) begin
      resolve_sp = u ? crs_pkg::IDX_USP : crs_pkg::IDX_ISP;
    end else begin
      resolve_sp = idx;
    end
  endfunction

  // Upper partner of a 32-bit pair, or none
  function automatic logic [4:0] pair_hi(input logic [4:0] lo);
    case (lo)
      crs_pkg::IDX_R0: pair_hi = crs_pkg::IDX_R2;
      crs_pkg::IDX_R1: pair_hi = crs_pkg::IDX_R3;
      crs_pkg::IDX_A0: pair_hi = crs_pkg::IDX_A1;
      default:         pair_hi = crs_pkg::IDX_NONE;
    endcase
  endfunction

  // Byte-lane merge; only the two wide registers keep bits 19:16
  function automatic logic [19:0] merge(input logic [19:0] old, input logic [19:0] data,
                                        input logic [2:0] be, input logic [4:0] idx);
    logic [19:0] m;
    m = old;
    if (be[0]) m[7:0] = data[7:0];
    if (be[1]) m[15:8] = data[15:8];
    if (be[2]) m[19:16] = data[19:16];
    if (idx != crs_pkg::IDX_VECTOR_TABLE_BASE && idx != crs_pkg::IDX_PC) begin
      m[19:16] = 4'h0;
    end
    merge = m;
  endfunction

  wire logic cur_bank = flag_reg[crs_pkg::FLG_B];
  wire logic cur_u    = flag_reg[crs_pkg::FLG_U];

  // Bus decode
  wire logic       bus_req    = avs_read | avs_write;
  wire logic       bus_commit = bus_req & ~wait_reg;
  wire logic [4:0] bus_idx    = avs_address[6:2];
  wire logic       bus_mapped = ~avs_address[7] & (avs_address[1:0] == 2'b00)
                                & (bus_idx <= crs_pkg::IDX_PAIR_A);
  wire logic       bus_wr_ok  = bus_commit & avs_write & bus_mapped;
  wire logic       bus_pair   = bus_idx >= crs_pkg::IDX_PAIR_D0;
  wire logic [4:0] bus_pair_lo = (bus_idx == crs_pkg::IDX_PAIR_D0) ? crs_pkg::IDX_R0 :
                                 (bus_idx == crs_pkg::IDX_PAIR_D1) ? crs_pkg::IDX_R1 :
                                 crs_pkg::IDX_A0;
  wire logic [4:0] bus_lo_idx = bus_pair ? bus_pair_lo : resolve_sp(bus_idx, cur_u);
  wire logic [4:0] bus_hi_idx = pair_hi(bus_lo_idx);
  wire logic [2:0] bus_lo_be  = bus_pair ? {1'b0, avs_byteenable[1:0]} : avs_byteenable[2:0];
  wire logic       bus_lo_en  = bus_wr_ok & (bus_lo_idx <= crs_pkg::IDX_ISP);
  wire logic       bus_hi_en  = bus_wr_ok & bus_pair;
  wire logic       bus_flg_en = bus_wr_ok & (bus_idx == crs_pkg::IDX_FLG);

  // Core write decode; byte halves exist only on the first two data registers
  wire logic [4:0] core_lo_idx = resolve_sp(core_wr_idx, cur_u);
  wire logic       core_small  = core_lo_idx <= crs_pkg::IDX_R1;
  wire logic       core_is_byte = (core_wr_size == crs_pkg::CRS_SZ_BYTE_LO)
                                  | (core_wr_size == crs_pkg::CRS_SZ_BYTE_HI);
  wire logic       core_is_long = core_wr_size == crs_pkg::CRS_SZ_LONG;
  wire logic [4:0] core_hi_idx = pair_hi(core_lo_idx);
  wire logic [2:0] core_lo_be  = (core_wr_size == crs_pkg::CRS_SZ_BYTE_LO) ? 3'h1 :
                                 (core_wr_size == crs_pkg::CRS_SZ_BYTE_HI) ? 3'h2 :
                                 core_is_long ? 3'h3 : 3'h7;
  wire logic [19:0] core_lo_data = (core_wr_size == crs_pkg::CRS_SZ_BYTE_HI) ?
                                   {4'h0, core_wr_data[7:0], 8'h00} : core_wr_data[19:0];
  wire logic       core_lo_en  = core_wr & (core_lo_idx <= crs_pkg::IDX_ISP)
                                 & (~core_is_byte | core_small)
                                 & (~core_is_long | (core_hi_idx != crs_pkg::IDX_NONE));
  wire logic       core_hi_en  = core_lo_en & core_is_long;
  wire logic       core_flg_en = core_wr & (core_wr_idx == crs_pkg::IDX_FLG);

  // Register file next state; the core port is applied last and wins
  always_comb begin
    for (int k = 0; k < NR; k++) begin
      file_next[k] = file_reg[k];
    end
    if (bus_lo_en) begin
      file_next[phys(bus_lo_idx, cur_bank)] =
        merge(file_reg[phys(bus_lo_idx, cur_bank)], avs_writedata[19:0], bus_lo_be,
              bus_lo_idx);
    end
    if (bus_hi_en) begin
      file_next[phys(bus_hi_idx, cur_bank)] =
        merge(file_reg[phys(bus_hi_idx, cur_bank)], {4'h0, avs_writedata[31:16]},
              {1'b0, avs_byteenable[3:2]}, bus_hi_idx);
    end
    if (core_lo_en) begin
      file_next[phys(core_lo_idx, cur_bank)] =
        merge(file_next[phys(core_lo_idx, cur_bank)], core_lo_data, core_lo_be,
              core_lo_idx);
    end
    if (core_hi_en) begin
      file_next[phys(core_hi_idx, cur_bank)] =
        merge(file_next[phys(core_hi_idx, cur_bank)], {4'h0, core_wr_data[31:16]}, 3'h3,
              core_hi_idx);
    end
  end

  // Flag next state: writes first, then arithmetic, then interrupt acceptance
  wire logic alu_zero = alu_byte ? (alu_result[7:0] == 8'h00) : (alu_result == 16'h0000);
  wire logic alu_sign = alu_byte ? alu_result[7] : alu_result[15];
  wire logic sw_u_clr = ack_sw & (ack_sw_num <= crs_pkg::SW_INT_U_MAX);

  always_comb begin
    flag_next = flag_reg;
    if (bus_flg_en && avs_byteenable[0]) begin
      flag_next[7:0] = avs_writedata[7:0];
    end
    if (bus_flg_en && avs_byteenable[1]) begin
      flag_next[10:8] = avs_writedata[10:8];
    end
    if (core_flg_en) begin
      flag_next = core_wr_data[10:0];
    end
    if (alu_update) begin
      if (alu_flag_mask[0]) flag_next[crs_pkg::FLG_C] = alu_carry;
      if (alu_flag_mask[1]) flag_next[crs_pkg::FLG_Z] = alu_zero;
      if (alu_flag_mask[2]) flag_next[crs_pkg::FLG_S] = alu_sign;
      if (alu_flag_mask[3]) flag_next[crs_pkg::FLG_O] = alu_overflow;
    end
    // Acceptance beats a same-cycle write that would set the flags again
    if (ack_hw || ack_sw) begin
      flag_next[crs_pkg::FLG_I] = 1'b0;
    end
    if (ack_hw || sw_u_clr) begin
      flag_next[crs_pkg::FLG_U] = 1'b0;
    end
  end

  // Bus read mux over current state
  logic [31:0] rd_word;
  wire  logic [4:0] rd_sp = resolve_sp(crs_pkg::IDX_SP, cur_u);

  always_comb begin
    rd_word = 32'h0000_0000;
    if (bus_mapped) begin
      case (bus_idx)
        crs_pkg::IDX_FLG:     rd_word = {21'h000000, flag_reg};
        crs_pkg::IDX_SP:      rd_word = {12'h000, file_reg[phys(rd_sp, cur_bank)]};
        crs_pkg::IDX_PAIR_D0: rd_word = {file_reg[phys(crs_pkg::IDX_R2, cur_bank)][15:0],
                                         file_reg[phys(crs_pkg::IDX_R0, cur_bank)][15:0]};
        crs_pkg::IDX_PAIR_D1: rd_word = {file_reg[phys(crs_pkg::IDX_R3, cur_bank)][15:0],
                                         file_reg[phys(crs_pkg::IDX_R1, cur_bank)][15:0]};
        crs_pkg::IDX_PAIR_A:  rd_word = {file_reg[phys(crs_pkg::IDX_A1, cur_bank)][15:0],
                                         file_reg[phys(crs_pkg::IDX_A0, cur_bank)][15:0]};
        default:              rd_word = {12'h000, file_reg[phys(bus_idx, cur_bank)]};
      endcase
    end
  end

  // Views from next state to match storage
  wire logic       nx_bank = flag_next[crs_pkg::FLG_B];
  wire logic       nx_u    = flag_next[crs_pkg::FLG_U];
  wire logic [4:0] nx_sp   = resolve_sp(crs_pkg::IDX_SP, nx_u);
  wire logic [15:0] nx_r0  = file_next[phys(crs_pkg::IDX_R0, nx_bank)][15:0];
  wire logic [15:0] nx_r1  = file_next[phys(crs_pkg::IDX_R1, nx_bank)][15:0];
  wire logic [15:0] nx_r2  = file_next[phys(crs_pkg::IDX_R2, nx_bank)][15:0];
  wire logic [15:0] nx_r3  = file_next[phys(crs_pkg::IDX_R3, nx_bank)][15:0];
  wire logic [15:0] nx_a0  = file_next[phys(crs_pkg::IDX_A0, nx_bank)][15:0];
  wire logic [15:0] nx_a1  = file_next[phys(crs_pkg::IDX_A1, nx_bank)][15:0];
  wire logic [2:0]  cur_ipl = flag_reg[crs_pkg::FLG_IPL +: 3];
  wire logic        permit_next = irq_req & (irq_level > cur_ipl)
                                  & (~irq_maskable | flag_reg[crs_pkg::FLG_I]);

  // Bus handshake: one wait cycle, then the request completes
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wait_reg  <= 1'b1;
      rdata_reg <= 32'h0000_0000;
    end else begin
      wait_reg <= ~(bus_req & wait_reg);
      if (bus_req && wait_reg) begin
        rdata_reg <= rd_word;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int k = 0; k < NR; k++) begin
        file_reg[k] <= crs_pkg::REG_RESET;
      end
      flag_reg <= crs_pkg::FLG_RESET;
    end else begin
      file_reg <= file_next;
      flag_reg <= flag_next;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      permit_reg  <= 1'b0;
      pair_lo_reg <= 32'h0000_0000;
      pair_hi_reg <= 32'h0000_0000;
      apair_reg   <= 32'h0000_0000;
      fb_reg      <= 16'h0000;
      sb_reg      <= 16'h0000;
      vector_table_base_reg    <= 20'h00000;
      pc_reg      <= 20'h00000;
      sp_reg      <= 16'h0000;
      flg_out_reg <= crs_pkg::FLG_RESET;
    end else begin
      permit_reg  <= permit_next;
      pair_lo_reg <= {nx_r2, nx_r0};
      pair_hi_reg <= {nx_r3, nx_r1};
      apair_reg   <= {nx_a1, nx_a0};
      fb_reg      <= file_next[phys(crs_pkg::IDX_FB, nx_bank)][15:0];
      sb_reg      <= file_next[phys(crs_pkg::IDX_SB, nx_bank)][15:0];
      vector_table_base_reg    <= file_next[phys(crs_pkg::IDX_VECTOR_TABLE_BASE, nx_bank)];
      pc_reg      <= file_next[phys(crs_pkg::IDX_PC, nx_bank)];
      sp_reg      <= file_next[phys(nx_sp, nx_bank)][15:0];
      flg_out_reg <= flag_next;
    end
  end

  assign avs_waitrequest          = wait_reg;
  assign avs_readdata             = rdata_reg;
  assign irq_permit               = permit_reg;
  assign data_pair_low            = pair_lo_reg;
  assign data_pair_high           = pair_hi_reg;
  assign addr_pair                = apair_reg;
  assign frame_base               = fb_reg;
  assign static_base              = sb_reg;
  assign vector_table_base        = vector_table_base_reg;
  assign next_instr_address       = pc_reg;
  assign active_sp                = sp_reg;
  assign cpu_status_flags         = flg_out_reg;
  assign bank_sel                 = flg_out_reg[crs_pkg::FLG_B];
  assign int_enable               = flg_out_reg[crs_pkg::FLG_I];
  assign processor_priority_level = flg_out_reg[crs_pkg::FLG_IPL +: 3];

endmodule

// ---- test/crs_core_model.sv ----
// Core-side partner: writes, flag updates and interrupt pulses.
// Assumes its tasks are called one at a time.
`timescale 1ns/1ps

module crs_core_model (
  // Clock
  input  wire logic         clock,
  // Core write port
  output logic              core_wr,
  output logic [4:0]        core_wr_idx,
  output crs_pkg::crs_size_t core_wr_size,
  output logic [31:0]       core_wr_data,
  // Arithmetic unit
  output logic              alu_update,
  output logic              alu_byte,
  output logic [15:0]       alu_result,
  output logic              alu_carry,
  output logic              alu_overflow,
  output logic [3:0]        alu_flag_mask,
  // Interrupts
  output logic              irq_req,
  output logic              irq_maskable,
  output logic [2:0]        irq_level,
  output logic              ack_hw,
  output logic              ack_sw,
  output logic [5:0]        ack_sw_num
);
  initial begin
    {core_wr, core_wr_idx, core_wr_data, alu_update, alu_byte, alu_result} = '0;
    {alu_carry, alu_overflow, alu_flag_mask, irq_req, irq_maskable} = '0;
    {irq_level, ack_hw, ack_sw, ack_sw_num} = '0;
    core_wr_size = crs_pkg::CRS_SZ_WORD;
  end

  task automatic core_write(input logic [4:0] idx, input crs_pkg::crs_size_t sz,
                            input logic [31:0] d);
    @(posedge clock);
    core_wr      <= 1'b1;
    core_wr_idx  <= idx;
    core_wr_size <= sz;
    // Flag writes never carry the debug or reserved bit
    core_wr_data <= (idx == crs_pkg::IDX_FLG) ? (d & 32'h0000_07fd) : d;
    @(posedge clock);
    core_wr <= 1'b0;
  endtask

  task automatic alu_op(input logic b, input logic [15:0] r, input logic c, o,
                        input logic [3:0] m);
    @(posedge clock);
    {alu_update, alu_byte, alu_result, alu_carry, alu_overflow, alu_flag_mask} <=
      {1'b1, b, r, c, o, m};
    @(posedge clock);
    alu_update <= 1'b0;
  endtask

  task automatic ack(input logic hw, sw, input logic [5:0] num);
    @(posedge clock);
    {ack_hw, ack_sw, ack_sw_num} <= {hw, sw, num};
    @(posedge clock);
    {ack_hw, ack_sw} <= 2'b00;
  endtask

  // Request lines are levels, held until the next call
  task automatic set_irq(input logic req, mk, input logic [2:0] lvl);
    @(posedge clock);
    {irq_req, irq_maskable, irq_level} <= {req, mk, lvl};
  endtask
endmodule

// ---- test/crs_register_set_checker.sv ----
// Concurrent checks on bus, flags and interrupt permit.
// Sees only top-level ports; bound below.
`timescale 1ns/1ps

module crs_register_set_checker (
  // Clock, reset and bus
  input wire logic        clock, nrst, avs_read, avs_write, avs_waitrequest,
  input wire logic [7:0]  avs_address,
  input wire logic [31:0] avs_readdata,
  // Core side
  input wire logic        alu_update, alu_byte, alu_carry, alu_overflow,
  input wire logic [15:0] alu_result,
  input wire logic [3:0]  alu_flag_mask,
  input wire logic        irq_req, irq_maskable, ack_hw, ack_sw, irq_permit,
  input wire logic [2:0]  irq_level, processor_priority_level,
  input wire logic [5:0]  ack_sw_num,
  input wire logic [10:0] cpu_status_flags,
  input wire logic        bank_sel, int_enable
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_done;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  bus_handshake_a: assert property (s_req |=> s_done)
    else $error("bus wait cycle wrong");
  flag_reserved_a: assert property (avs_read && !avs_waitrequest &&
    avs_address == crs_pkg::OFF_FLG |-> avs_readdata[31:11] == '0) else $error("flag bits");
  unmapped_zero_a: assert property (avs_read && !avs_waitrequest &&
    avs_address >= 8'h44 |-> avs_readdata == '0) else $error("unmapped read not zero");
  flag_layout_a: assert property (bank_sel == cpu_status_flags[crs_pkg::FLG_B] &&
    int_enable == cpu_status_flags[crs_pkg::FLG_I] &&
    processor_priority_level == cpu_status_flags[10:8]) else $error("flag copies differ");
  zero_flag_a: assert property (alu_update && alu_flag_mask[1] |=>
    cpu_status_flags[crs_pkg::FLG_Z] == ($past(alu_byte) ? ($past(alu_result[7:0]) == 0)
    : ($past(alu_result) == 0))) else $error("zero flag wrong");
  sign_flag_a: assert property (alu_update && alu_flag_mask[2] |=>
    cpu_status_flags[crs_pkg::FLG_S] == ($past(alu_byte) ? $past(alu_result[7])
    : $past(alu_result[15]))) else $error("sign flag wrong");
  carry_flag_a: assert property (alu_update && alu_flag_mask[0] |=>
    cpu_status_flags[crs_pkg::FLG_C] == $past(alu_carry)) else $error("carry flag wrong");
  overflow_flag_a: assert property (alu_update && alu_flag_mask[3] |=>
    cpu_status_flags[crs_pkg::FLG_O] == $past(alu_overflow)) else $error("overflow wrong");
  int_clear_a: assert property ((ack_hw || ack_sw) |=> !int_enable)
    else $error("enable not cleared");
  stack_clear_a: assert property ((ack_hw || (ack_sw &&
    ack_sw_num <= crs_pkg::SW_INT_U_MAX)) |=> !cpu_status_flags[crs_pkg::FLG_U])
    else $error("stack select not cleared");
  permit_grant_a: assert property (irq_req && irq_level > processor_priority_level &&
    (!irq_maskable || int_enable) |=> irq_permit) else $error("permit missing");
  permit_deny_a: assert property (!irq_req || irq_level <= processor_priority_level
    || (irq_maskable && !int_enable) |=> !irq_permit) else $error("permit unexpected");
endmodule

bind crs_register_set crs_register_set_checker i_chk (.*);

// ---- test/tb_crs_register_set.sv ----
// Self-checking bench with bus master tasks and the core model.
// Assumes the bound checker runs alongside.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end

module tb_crs_register_set;
  logic        clock = 1'b0, nrst = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [7:0]  avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd, data_pair_low, data_pair_high;
  logic [31:0] addr_pair, core_wr_data;
  logic        avs_waitrequest, irq_permit, bank_sel, int_enable, core_wr, alu_update;
  logic        alu_byte, alu_carry, alu_overflow, irq_req, irq_maskable, ack_hw, ack_sw;
  logic [15:0] frame_base, static_base, active_sp, alu_result;
  logic [19:0] vector_table_base, next_instr_address;
  logic [10:0] cpu_status_flags;
  logic [4:0]  core_wr_idx;
  logic [3:0]  alu_flag_mask;
  logic [2:0]  processor_priority_level, irq_level;
  logic [5:0]  ack_sw_num;
  crs_pkg::crs_size_t core_wr_size;
  int          failures = 0, n_compared = 0;

  always #5 clock = ~clock;

  crs_register_set i_dut (.*, .avs_byteenable(4'hf));
  crs_core_model i_core (.*);

  task automatic test_done();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Held until waitrequest samples low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clock);
    {avs_address, avs_writedata, avs_read, avs_write} <= {a, d, !wr, wr};
    do begin @(posedge clock); n++; end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) failures++;
    rd = avs_readdata;
    {avs_read, avs_write} <= 2'b00;
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(nm, e, rd)
  endtask

  task automatic t_regs();
    logic [31:0] d;
    for (int a = 0; a <= 8'h44; a += 4) rdchk("reset value", a[7:0], 32'h0);
    for (int a = 0; a <= 8'h2c; a += 4) bus(1'b1, a[7:0], 32'hc3c3_0003 | (a << 12) | (a << 4));
    for (int a = 0; a <= 8'h2c; a += 4) begin
      d = 32'hc3c3_0003 | (a << 12) | (a << 4);
      rdchk("width", a[7:0], d & ((a == 8'h20 || a == 8'h24) ? 32'hfffff : 32'hffff));
    end
    bus(1'b1, 8'h44, 32'h1234_5678);
    rdchk("unmapped", 8'h44, 32'h0);
    @(negedge clock);
    `CHK("pc view", 20'h34243, next_instr_address)
    `CHK("table base view", 20'h30203, vector_table_base)
    $display("t_regs done");
  endtask

  task automatic t_pairs();
    bus(1'b1, crs_pkg::OFF_PAIR_D0, 32'h1234_5678);
    rdchk("pair low half", crs_pkg::OFF_R0, 32'h5678);
    rdchk("pair high half", crs_pkg::OFF_R2, 32'h1234);
    i_core.core_write(crs_pkg::IDX_R1, crs_pkg::CRS_SZ_LONG, 32'hcafe_beef);
    i_core.core_write(crs_pkg::IDX_A0, crs_pkg::CRS_SZ_LONG, 32'h0bad_f00d);
    rdchk("address upper", crs_pkg::OFF_A1, 32'h0bad);
    `CHK("addr_pair", 32'h0bad_f00d, addr_pair)
    i_core.core_write(crs_pkg::IDX_R0, crs_pkg::CRS_SZ_BYTE_HI, 32'h99);
    i_core.core_write(crs_pkg::IDX_R1, crs_pkg::CRS_SZ_BYTE_LO, 32'h11);
    @(negedge clock);
    `CHK("upper byte", 32'h1234_9978, data_pair_low)
    `CHK("lower byte", 32'hcafe_be11, data_pair_high)
    $display("t_pairs done");
  endtask

  task automatic alu_chk(input logic b, input logic [15:0] r, input logic c, o, z, s);
    i_core.alu_op(b, r, c, o, 4'hf);
    @(negedge clock);
    `CHK("zero flag", z, cpu_status_flags[crs_pkg::FLG_Z])
    `CHK("sign flag", s, cpu_status_flags[crs_pkg::FLG_S])
    `CHK("carry flag", c, cpu_status_flags[crs_pkg::FLG_C])
    `CHK("overflow flag", o, cpu_status_flags[crs_pkg::FLG_O])
  endtask

  task automatic t_flags();
    alu_chk(1'b0, 16'h0000, 1'b1, 1'b0, 1'b1, 1'b0);
    alu_chk(1'b0, 16'h8000, 1'b0, 1'b1, 1'b0, 1'b1);
    alu_chk(1'b1, 16'h0100, 1'b1, 1'b1, 1'b1, 1'b0);
    alu_chk(1'b1, 16'h0080, 1'b0, 1'b0, 1'b0, 1'b1);
    i_core.alu_op(1'b0, 16'h0000, 1'b1, 1'b1, 4'h0);
    @(negedge clock);
    `CHK("masked update", 4'b1000, cpu_status_flags[3:0])
    $display("t_flags done");
  endtask

  task automatic t_bank();
    // User stack, interrupts on, level 3; debug and reserved bits low
    bus(1'b1, crs_pkg::OFF_FLG, 32'h0000_03c0);
    rdchk("flags", crs_pkg::OFF_FLG, 32'h0000_03c0);
    bus(1'b1, crs_pkg::OFF_USP, 32'h1111);
    bus(1'b1, crs_pkg::OFF_ISP, 32'h2222);
    rdchk("active stack", crs_pkg::OFF_SP, 32'h1111);
    `CHK("priority", 3'd3, processor_priority_level)
    bus(1'b1, crs_pkg::OFF_R0, 32'haaaa);
    bus(1'b1, crs_pkg::OFF_FLG, 32'h0000_03d0);
    rdchk("bank one", crs_pkg::OFF_R0, 32'h0);
    `CHK("bank_sel", 1'b1, bank_sel)
    bus(1'b1, crs_pkg::OFF_R0, 32'hbbbb);
    bus(1'b1, crs_pkg::OFF_FLG, 32'h0000_03c0);
    rdchk("bank zero", crs_pkg::OFF_R0, 32'haaaa);
    $display("t_bank done");
  endtask

  task automatic irq_chk(input logic req, mk, input logic [2:0] lvl, input logic e);
    i_core.set_irq(req, mk, lvl);
    repeat (2) @(negedge clock);
    `CHK("irq_permit", e, irq_permit)
  endtask

  task automatic t_irq();
    irq_chk(1'b1, 1'b1, 3'd4, 1'b1);
    irq_chk(1'b1, 1'b1, 3'd3, 1'b0);
    irq_chk(1'b0, 1'b1, 3'd7, 1'b0);
    i_core.ack(1'b0, 1'b1, 6'd32);
    @(negedge clock);
    `CHK("enable after accept", 1'b0, int_enable)
    `CHK("user stack kept", 16'h1111, active_sp)
    irq_chk(1'b1, 1'b1, 3'd7, 1'b0);
    irq_chk(1'b1, 1'b0, 3'd7, 1'b1);
    bus(1'b1, crs_pkg::OFF_FLG, 32'h0000_03c0);
    i_core.ack(1'b0, 1'b1, 6'd31);
    @(negedge clock);
    `CHK("interrupt stack", 16'h2222, active_sp)
    bus(1'b1, crs_pkg::OFF_FLG, 32'h0000_03c0);
    i_core.ack(1'b1, 1'b0, 6'd0);
    @(negedge clock);
    `CHK("hw accept", 2'b00, {cpu_status_flags[crs_pkg::FLG_U], int_enable})
    i_core.set_irq(1'b0, 1'b0, 3'd0);
    $display("t_irq done");
  endtask

  initial begin
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    repeat (3) @(posedge clock);
    `CHK("idle waitrequest", 1'b1, avs_waitrequest)
    t_regs();
    t_pairs();
    t_flags();
    t_bank();
    t_irq();
    test_done();
  end

  initial begin
    #200000;
    failures++;
    test_done();
  end
endmodule
